// File: hw/rsc_pkg.sv
// shared constants and carrier types of the reset and stop recovery block
package rsc_pkg;
  localparam logic [11:0] ADDR_STATUS = 12'h0ff0;
  localparam logic [11:0] ADDR_CTRL = 12'h0fe0;
  localparam logic [11:0] ADDR_LVD = 12'h0fe4;
  localparam logic [11:0] ADDR_SMR_EN = 12'h0fe8;
  localparam logic [11:0] ADDR_DBG = 12'h0fec;
  localparam int ST_POR = 7;
  localparam int ST_STOP = 6;
  localparam int ST_WDT = 5;
  localparam int ST_EXT = 4;
  localparam int ST_LVD = 0;
  localparam logic [7:0] WDT_CTRL_RST = 8'h00;
  localparam logic [7:0] OSC_CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LVD_RST = 8'h00;
  localparam logic [7:0] SMR_EN_RST = 8'h00;
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0002;
  localparam int CLK_MHZ = 250;
  localparam int IPO_STARTUP_NS = 4000;
  localparam int STARTUP_CYC = (IPO_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_SHORT = 66;
  localparam int HOLD_XTAL = 5000;
  localparam int EXT_MIN_CYC = 3;
  localparam int SLV_CNT_W = 13;
  typedef struct packed {
    logic por;
    logic bor;
    logic wdt_to;
    logic dbg_pin_low;
    logic stop_mode;
    logic ipo_running;
    logic supply_ok;
    logic lvd_below;
  } rsc_src_t;
  typedef struct packed {
    logic cpu_rst;
    logic periph_rst;
    logic ctrl_reg_load;
    logic wdt_osc_reload;
    logic clk_sel_ipo;
    logic fetch_vector;
  } rsc_ctl_t;
endpackage

// File: hw/rsc_ctrl.sv
// reset and stop recovery sequencer with apb status and control registers
//
// Overview of operation
// - system reset from por, brownout, watchdog, pin, debugger
// - stop recovery on watchdog or enabled gpio change
// - hold 66 ipo cycles without crystal
// - hold 5000 ipo cycles with crystal
// - ipo start-up wait before hold count
// - stop recovery keeps control registers, except two
// - power reset counting starts once supply ok
// - stay in reset while pin held
// - gpio inputs, pull-ups off, except reset pin
// - reset pin open-drain, driven low during reset
// - cpu idle; oscillators keep running in reset
// - control registers loaded with reset values
// - cpu fetches vector at 0002h and 0003h
// - ipo selected as clock after reset
// - ignore pin pulses under three clocks
// - debugger reset spares the debugger
// - in stop, analog-filtered pin or debug pin resets
// - set power flag after power-on hold
// - low voltage interrupt below software level
// - status reads and watchdog writes share address
// - set external flag after pin reset
// - set watchdog flag on watchdog reset
// - set stop flag after stop recovery
`timescale 1ns/10ps
module rsc_ctrl #(
  parameter int HOLD_XTAL_CYC = rsc_pkg::HOLD_XTAL
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // sources
  input wire rsc_pkg::rsc_src_t src_i,
  input wire logic wdt_reset_select_option_i,
  input wire logic xtal_enable_option_i,
  input wire logic [7:0] gpio_in_i,
  // reset-shared pin, open-drain
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_n_o,
  // outputs to the core
  output rsc_pkg::rsc_ctl_t ctl_o,
  output logic [15:0] vector_addr_o,
  output logic gpio_dir_input_o,
  output logic gpio_pullup_off_o,
  output logic ocd_keep_o,
  output logic [7:0] watchdog_control_reg_o,
  output logic [7:0] oscillator_control_reg_o,
  output logic low_voltage_irq_o
);
  typedef enum logic [2:0] {
    S_WAIT_SUPPLY, S_STARTUP, S_HOLD, S_PIN_WAIT, S_RUN
  } rsc_state_t;

  typedef struct packed {
    rsc_state_t state;
    logic [rsc_pkg::SLV_CNT_W-1:0] cnt;
    logic sys_rst;
    logic stop_recovery;
    logic [3:0] cause;
    logic [7:0] status;
    logic [7:0] wdt_ctrl;
    logic [7:0] osc_ctrl;
    logic [7:0] ctrl;
    logic [7:0] lvd_level;
    logic [7:0] smr_en;
    logic dbg_rst;
    logic [1:0] pin_sync;
    logic [1:0] pin_lo_cnt;
    logic [7:0] gpio_s1;
    logic [7:0] gpio_s2;
    logic [7:0] gpio_prev;
    logic [1:0] dbgp_sync;
    logic lvd_irq;
    logic [31:0] rdata;
  } rsc_reg_t;

  rsc_reg_t q, d;

  logic wr, rd, pin_low, pin_rst, dbgp_low, por_src, any_sys, any_smr;
  logic [rsc_pkg::SLV_CNT_W-1:0] hold_len;

  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & ~penable_i & ~pwrite_i;
  assign pin_low = ~q.pin_sync[1];
  assign dbgp_low = ~q.dbgp_sync[1];
  assign por_src = src_i.por | src_i.bor | (q.state == S_WAIT_SUPPLY);

  always_comb begin
    d = q;
    d.pin_sync = {q.pin_sync[0], reset_pin_i};
    d.dbgp_sync = {q.dbgp_sync[0], src_i.dbg_pin_low ? 1'b0 : 1'b1};
    d.gpio_s1 = gpio_in_i;
    d.gpio_s2 = q.gpio_s1;
    d.gpio_prev = q.gpio_s2;
    // width filter: a pulse of three synced clocks is taken
    if (!pin_low) begin
      d.pin_lo_cnt = 2'h0;
    end else if (q.pin_lo_cnt != 2'h3) begin
      d.pin_lo_cnt = q.pin_lo_cnt + 2'h1;
    end
    // in stop the analog filter upstream already rejects short pulses
    pin_rst = q.ctrl[0] & pin_low &
      (src_i.stop_mode ? 1'b1 : (q.pin_lo_cnt >= 2'(rsc_pkg::EXT_MIN_CYC - 1)));
    hold_len = xtal_enable_option_i ? rsc_pkg::SLV_CNT_W'(HOLD_XTAL_CYC)
      : rsc_pkg::SLV_CNT_W'(rsc_pkg::HOLD_SHORT);
    any_sys = src_i.por | src_i.bor
      | (src_i.wdt_to & wdt_reset_select_option_i & ~src_i.stop_mode)
      | pin_rst | q.dbg_rst
      | (src_i.stop_mode & dbgp_low);
    any_smr = src_i.stop_mode & (src_i.wdt_to
      | |((q.gpio_s2 ^ q.gpio_prev) & q.smr_en));
    if (src_i.lvd_below && q.lvd_level != 8'h00) begin
      d.lvd_irq = 1'b1;
    end
    if (any_sys) begin
      d.sys_rst = 1'b1;
      d.stop_recovery = 1'b0;
      d.cause = {src_i.por | src_i.bor | q.dbg_rst,
        1'b0, src_i.wdt_to & wdt_reset_select_option_i, pin_rst};
      d.state = (src_i.por | src_i.bor) ? S_WAIT_SUPPLY : S_STARTUP;
      d.cnt = '0;
      d.ctrl = rsc_pkg::CTRL_RST;
      d.lvd_level = rsc_pkg::LVD_RST;
      d.smr_en = rsc_pkg::SMR_EN_RST;
      d.lvd_irq = 1'b0;
      d.dbg_rst = 1'b0;
      d.wdt_ctrl = rsc_pkg::WDT_CTRL_RST;
      d.osc_ctrl = rsc_pkg::OSC_CTRL_RST;
    end else if (any_smr && q.state == S_RUN) begin
      d.stop_recovery = 1'b1;
      d.sys_rst = 1'b0;
      d.cause = {1'b0, 1'b1, src_i.wdt_to, 1'b0};
      d.state = S_STARTUP;
      d.cnt = '0;
      d.wdt_ctrl = rsc_pkg::WDT_CTRL_RST;
      d.osc_ctrl = rsc_pkg::OSC_CTRL_RST;
    end else begin
      case (q.state)
        S_WAIT_SUPPLY: begin
          if (src_i.supply_ok && !por_src) begin
            d.state = S_STARTUP;
          end else if (src_i.supply_ok && !src_i.por && !src_i.bor) begin
            d.state = S_STARTUP;
          end
          d.cnt = '0;
        end
        S_STARTUP: begin
          if (src_i.ipo_running &&
              q.cnt >= rsc_pkg::SLV_CNT_W'(rsc_pkg::STARTUP_CYC - 1)) begin
            d.state = S_HOLD;
            d.cnt = '0;
          end else if (q.cnt <
              rsc_pkg::SLV_CNT_W'(rsc_pkg::STARTUP_CYC - 1)) begin
            // saturates so a late oscillator cannot wrap the count
            d.cnt = q.cnt + 1'b1;
          end
        end
        S_HOLD: begin
          if (q.cnt >= hold_len - 1'b1) begin
            // our own drive masks the pin, so after a pin reset we let go
            // and look again; costs the synchroniser delay on exit
            d.state = q.cause[0] ? S_PIN_WAIT : S_RUN;
            d.cnt = '0;
            if (!q.cause[0]) begin
              d.status = {q.cause[3], q.cause[2], q.cause[1], q.cause[0],
                4'h0};
            end
          end else begin
            d.cnt = q.cnt + 1'b1;
          end
        end
        S_PIN_WAIT: begin
          if (!pin_low) begin
            d.state = S_RUN;
            d.status = {q.cause, 4'h0};
          end
        end
        S_RUN: begin
          d.sys_rst = 1'b0;
          d.stop_recovery = 1'b0;
          if (wr) begin
            case (paddr_i)
              rsc_pkg::ADDR_STATUS: d.wdt_ctrl = pwdata_i[7:0];
              rsc_pkg::ADDR_CTRL: d.ctrl = pwdata_i[7:0];
              rsc_pkg::ADDR_LVD: d.lvd_level = pwdata_i[7:0];
              rsc_pkg::ADDR_SMR_EN: d.smr_en = pwdata_i[7:0];
              rsc_pkg::ADDR_DBG: d.dbg_rst = pwdata_i[0];
              default: d.osc_ctrl = q.osc_ctrl;
            endcase
          end
          if (wr && paddr_i == rsc_pkg::ADDR_LVD && pwdata_i[8]) begin
            d.lvd_irq = src_i.lvd_below & (q.lvd_level != 8'h00);
          end
        end
        default: d.state = S_WAIT_SUPPLY;
      endcase
    end
    if (rd) begin
      case (paddr_i)
        rsc_pkg::ADDR_STATUS:
          d.rdata = {24'h0, q.status[7:4], 3'h0, q.lvd_irq};
        rsc_pkg::ADDR_CTRL: d.rdata = {24'h0, q.ctrl};
        rsc_pkg::ADDR_LVD: d.rdata = {24'h0, q.lvd_level};
        rsc_pkg::ADDR_SMR_EN: d.rdata = {24'h0, q.smr_en};
        rsc_pkg::ADDR_DBG: d.rdata = {31'h0, q.dbg_rst};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.state <= S_WAIT_SUPPLY;
      q.sys_rst <= 1'b1;
      q.cause <= 4'h8;
      q.ctrl <= rsc_pkg::CTRL_RST;
      q.pin_sync <= 2'h3;
      q.dbgp_sync <= 2'h3;
    end else begin
      q <= d;
    end
  end

  logic in_rst;
  assign in_rst = (q.state != S_RUN);
  always_comb begin
    ctl_o.cpu_rst = in_rst;
    ctl_o.periph_rst = in_rst & q.sys_rst;
    ctl_o.ctrl_reg_load = in_rst & q.sys_rst;
    ctl_o.wdt_osc_reload = in_rst;
    ctl_o.clk_sel_ipo = in_rst;
    ctl_o.fetch_vector = (d.state == S_RUN) & (q.state != S_RUN);
  end
  assign vector_addr_o = rsc_pkg::RESET_VEC_ADDR;
  assign gpio_dir_input_o = in_rst & q.sys_rst;
  assign gpio_pullup_off_o = in_rst & q.sys_rst;
  assign reset_pin_o = 1'b0;
  // released while waiting on the pin, else we would hold ourselves in reset
  assign reset_pin_oe_n_o = ~(in_rst & q.sys_rst
    & (q.state != S_PIN_WAIT));
  assign ocd_keep_o = 1'b1;
  assign watchdog_control_reg_o = q.wdt_ctrl;
  assign oscillator_control_reg_o = q.osc_ctrl;
  assign low_voltage_irq_o = q.lvd_irq;
  assign prdata_o = q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
endmodule

// File: tb/rsc_ctrl_properties.sv
// port assertions for the reset and stop recovery sequencer
`timescale 1ns/10ps
module rsc_ctrl_properties #(
  parameter int HOLD_XTAL_CYC = 5000
) (
  // clock, reset and bus
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // sources and options
  input wire rsc_pkg::rsc_src_t src_i,
  input wire logic xtal_enable_option_i,
  // pin and core side
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_n_o,
  input wire rsc_pkg::rsc_ctl_t ctl_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic gpio_dir_input_o,
  input wire logic gpio_pullup_off_o,
  input wire logic ocd_keep_o
);
  logic [15:0] hi_q;
  // saturates so a long pin hold cannot wrap the count
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !ctl_o.cpu_rst) hi_q <= 16'h0000;
    else if (hi_q != 16'hffff) hi_q <= hi_q + 16'h0001;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  AST_VECTOR: assert property (vector_addr_o == 16'h0002)
    else $error("vector address wrong");
  AST_FETCH_PULSE: assert property (ctl_o.fetch_vector |=>
    !ctl_o.fetch_vector) else $error("fetch pulse too long");
  AST_HOLD_LEN: assert property ($fell(ctl_o.cpu_rst) |->
    hi_q >= 16'(xtal_enable_option_i ? HOLD_XTAL_CYC + 998 : 1064))
    else $error("reset hold too short");
  AST_SUPPLY_LOW: assert property (!src_i.supply_ok |->
    ##[1:2] ctl_o.cpu_rst) else $error("cpu runs without supply");
  AST_PIN_LOW: assert property (!reset_pin_oe_n_o |-> !reset_pin_o)
    else $error("reset pin driven high");
  AST_PIN_DRIVE: assert property ($rose(ctl_o.cpu_rst) &&
    !src_i.stop_mode |-> ##[0:2] !reset_pin_oe_n_o)
    else $error("reset pin not driven");
  AST_GPIO_SAFE: assert property (!reset_pin_oe_n_o |->
    gpio_dir_input_o && gpio_pullup_off_o) else $error("gpio not safe");
  AST_OCD_KEEP: assert property (ocd_keep_o)
    else $error("debugger state dropped");
  AST_PREADY: assert property (psel_i |-> pready_o && !pslverr_o)
    else $error("bus answer wrong");
  AST_FETCH_EXIT: assert property ($fell(ctl_o.cpu_rst) |->
    $past(ctl_o.fetch_vector)) else $error("no vector fetch on exit");
  AST_PIN_RELEASE: assert property (!ctl_o.cpu_rst |->
    reset_pin_oe_n_o) else $error("reset pin driven while running");
endmodule
bind rsc_ctrl rsc_ctrl_properties #(.HOLD_XTAL_CYC(HOLD_XTAL_CYC)) u_chk (
  .mclk_i, .rst_n_i, .psel_i, .pready_o, .pslverr_o, .src_i,
  .xtal_enable_option_i, .reset_pin_o, .reset_pin_oe_n_o, .ctl_o,
  .vector_addr_o, .gpio_dir_input_o, .gpio_pullup_off_o, .ocd_keep_o);

// File: tb/rsc_far_side.sv
// far side: supply monitor and pulled-up reset pin
`timescale 1ns/10ps
module rsc_far_side (
  // clock and commands
  input wire logic mclk_i,
  input wire logic pwr_on_i,
  input wire logic ext_low_i,
  // device drive of the pin
  input wire logic pin_drv_i,
  input wire logic pin_oe_n_i,
  // seen by the device
  output logic pin_o,
  output logic supply_ok_o
);
  logic [2:0] ramp_q;
  // supply takes a few cycles to cross the threshold
  always_ff @(posedge mclk_i) begin
    ramp_q <= pwr_on_i ? {ramp_q[1:0], 1'b1} : 3'h0;
  end
  assign supply_ok_o = ramp_q[2];
  // pull-up wins unless someone sinks the line
  assign pin_o = !(ext_low_i || (!pin_oe_n_i && !pin_drv_i));
endmodule

// File: tb/reset_and_stop_recovery_controller_tb.sv
// self-checking bench for the reset and stop recovery sequencer
`timescale 1ns/10ps
module reset_and_stop_recovery_controller_tb;
  logic mclk = 0, rst_n = 0, psel = 0, pen = 0, pwrite = 0, pwr = 0;
  logic ext_low = 0, wdt = 0, stp = 0, xtal = 0, rdy, pin, pdrv, poe_n, sok;
  logic wsel = 1, lvd = 0, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [7:0] gpio = 8'h00, q, wctl;
  rsc_pkg::rsc_src_t src;
  rsc_pkg::rsc_ctl_t ctl;
  int n_mismatch = 0, checks = 0, k;
  localparam logic [11:0] RA [5] = '{12'h0ff0, 12'h0fe0, 12'h0fe4,
    12'h0fe8, 12'h0ff4};
  localparam logic [7:0] RV [5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  assign src = {!sok, 1'b0, wdt, 1'b0, stp, sok, sok, lvd};
  always #2 mclk = ~mclk;
  rsc_ctrl #(.HOLD_XTAL_CYC(20)) dut (.mclk_i(mclk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(),
    .src_i(src), .wdt_reset_select_option_i(wsel),
    .xtal_enable_option_i(xtal), .gpio_in_i(gpio), .reset_pin_i(pin),
    .reset_pin_o(pdrv), .reset_pin_oe_n_o(poe_n), .ctl_o(ctl),
    .vector_addr_o(), .gpio_dir_input_o(), .gpio_pullup_off_o(),
    .ocd_keep_o(), .watchdog_control_reg_o(wctl),
    .oscillator_control_reg_o(), .low_voltage_irq_o(irq));
  rsc_far_side far (.mclk_i(mclk), .pwr_on_i(pwr), .ext_low_i(ext_low),
    .pin_drv_i(pdrv), .pin_oe_n_i(poe_n), .pin_o(pin), .supply_ok_o(sok));
  task automatic wrap_up;
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge mclk);
    pen <= 1;
    do @(posedge mclk); while (rdy !== 1'b1);
    q = prdata[7:0];
    psel <= 0;
    pen <= 0;
  endtask
  // counts falling edges until the core reset reaches level v
  task automatic wait_rst(input logic v);
    k = 0;
    while (ctl.cpu_rst !== v && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    chk("reset_wait", 1, k < 3000);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    repeat (20) @(negedge mclk);
    chk("held_no_supply", 1, ctl.cpu_rst);
    @(posedge mclk) pwr <= 1;
    wait_rst(0);
    chk("hold_len", 1, k >= 1066 && k < 1090);
    for (int i = 0; i < 5; i++) begin
      apb(0, RA[i], 8'h00);
      chk("reg_read", RV[i], q);
    end
    @(posedge mclk) wdt <= 1;
    xtal <= 1;
    @(posedge mclk) wdt <= 0;
    wait_rst(1);
    wait_rst(0);
    chk("xtal_hold", 1, k >= 1020 && k < 1040);
    apb(0, 12'h0ff0, 8'h00);
    chk("wdt_flag", 1, q[5]);
    xtal <= 0;
    apb(1, 12'h0fec, 8'h01);
    wait_rst(1);
    wait_rst(0);
    apb(0, 12'h0ff0, 8'h00);
    chk("dbg_flag", 1, q[7]);
    apb(1, 12'h0ff0, 8'h5a);
    wsel <= 0;
    @(negedge mclk);
    chk("wdt_ctrl", 8'h5a, wctl);
    @(posedge mclk) wdt <= 1;
    @(posedge mclk) wdt <= 0;
    repeat (4) @(negedge mclk);
    chk("wdt_no_rst", 0, ctl.cpu_rst);
    apb(1, 12'h0fe4, 8'h05);
    lvd <= 1;
    repeat (2) @(negedge mclk);
    chk("lvd_irq", 1, irq);
    apb(0, 12'h0ff0, 8'h00);
    chk("lvd_flag", 8'h81, q);
    apb(1, 12'h0fe0, 8'h01);
    ext_low <= 1;
    repeat (2) @(posedge mclk);
    ext_low <= 0;
    repeat (10) @(negedge mclk);
    chk("short_pulse", 0, ctl.cpu_rst);
    @(posedge mclk) ext_low <= 1;
    repeat (1200) @(negedge mclk);
    chk("pin_held", 1, ctl.cpu_rst);
    @(posedge mclk) ext_low <= 0;
    wait_rst(0);
    chk("pin_exit", 1, k < 10);
    apb(0, 12'h0ff0, 8'h00);
    chk("ext_flag", 1, q[4]);
    apb(1, 12'h0fe8, 8'h01);
    apb(1, 12'h0ff0, 8'h5a);
    @(posedge mclk) stp <= 1;
    repeat (4) @(posedge mclk);
    gpio <= 8'h01;
    wait_rst(1);
    @(posedge mclk) stp <= 0;
    wait_rst(0);
    apb(0, 12'h0fe8, 8'h00);
    chk("kept_enable", 8'h01, q);
    apb(0, 12'h0ff0, 8'h00);
    chk("stop_flag", 1, q[6]);
    chk("wdt_ctrl_smr", 8'h00, wctl);
    @(posedge mclk) rst_n <= 0;
    repeat (2) @(negedge mclk);
    chk("rst_pin_drive", 0, poe_n);
    chk("rst_cpu", 1, ctl.cpu_rst);
    @(posedge mclk) rst_n <= 1;
    wait_rst(0);
    chk("rst_hold", 1, k >= 1066 && k < 1090);
    apb(0, 12'h0ff0, 8'h00);
    chk("rst_flag", 1, q[7]);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
